// file: verilog/ahs_pkg.sv
package ahs_pkg;
  localparam logic [7:0]  MODE_HOMING   = 8'h06;
  localparam int          START_BIT     = 4;
  localparam int          ST_TGT_BIT    = 10;
  localparam int          ST_HOMED_BIT  = 12;
  localparam int          ST_ERR_BIT    = 13;
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_MODE      = 8'h04;
  localparam logic [7:0]  OFS_METHOD    = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0c;
  localparam logic [7:0]  OFS_HOME_OFS  = 8'h10;
  localparam logic [7:0]  OFS_SPD_SW    = 8'h14;
  localparam logic [7:0]  OFS_SPD_ZERO  = 8'h18;
  localparam logic [7:0]  OFS_ACCEL     = 8'h1c;
  localparam logic [7:0]  OFS_TOL_BAND  = 8'h20;
  localparam logic [7:0]  OFS_BLK_CUR   = 8'h24;
  localparam logic [7:0]  OFS_BLK_MS    = 8'h28;
  localparam logic [7:0]  OFS_POS       = 8'h2c;
  // Reset values and bus response codes
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS    = 32'h0000_0400;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // Timing: one millisecond at the core clock
  localparam int          MS_NS         = 1000000;
  localparam int          CLK_NS        = 8;
  localparam int          MS_CYCLES     = MS_NS / CLK_NS;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEEK, ST_PUSH, ST_ZERO, ST_DONE, ST_ERR
  } ahs_state_t;
endpackage : ahs_pkg

// file: verilog/ahs_homing.sv
// Implementation choices: the AXI4-Lite register port and the register addresses.
module ahs_homing #(
  parameter int MS_CYCLES = ahs_pkg::MS_CYCLES // Cycles per ms
) (
  input  wire logic        core_clk,       // Core clock
  input  wire logic        reset_n,        // Sync reset, low
  input  wire logic [7:0]  s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write addr valid
  output logic             s_axi_awready,  // Write addr ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Byte enables
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write resp valid
  input  wire logic        s_axi_bready,   // Write resp ready
  input  wire logic [7:0]  s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read addr valid
  output logic             s_axi_arready,  // Read addr ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready,   // Read data ready
  input  wire logic        index_in,       // Encoder index
  input  wire logic        home_sw_in,     // Home switch
  input  wire logic        lim_pos_in,     // Positive limit
  input  wire logic        lim_neg_in,     // Negative limit
  input  wire logic [15:0] current_in,     // Motor current
  input  wire logic [15:0] pos_delta_in,   // Signed travel/cycle
  input  wire logic        standstill_in,  // Motor at rest
  input  wire logic        closed_loop_in, // Closed loop on
  input  wire logic        op_enabled_in,  // Operation enabled
  output logic [31:0]      speed_cmd,      // Signed speed
  output logic [31:0]      accel_cmd,      // Ramp acceleration
  output logic             fault_out,      // Overtravel fault
  output logic             homing_busy     // Sequence running
);
  if (MS_CYCLES < 1 || MS_CYCLES > 131071)
  begin : g_bad
    $error("MS_CYCLES out of range");
  end

  // Register file
  logic [31:0] ctrl_q;      // Control word
  logic [7:0]  mode_q;      // Operating mode selector
  logic [7:0]  method_q;    // Signed method number
  logic [31:0] home_ofs_q;  // Home offset
  logic [31:0] spd_sw_q;    // Switch search speed
  logic [31:0] spd_zero_q;  // Index search speed
  logic [31:0] accel_q;     // Homing acceleration
  logic [31:0] tol_q;       // Limit tolerance band
  logic [15:0] blk_cur_q;   // Block current threshold
  logic [15:0] blk_ms_q;    // Block push time in ms
  logic [31:0] pos_q;       // Actual position
  logic [31:0] status_q;    // Status word

  // Sequencer state
  ahs_pkg::ahs_state_t st_q;
  logic        dir_q;       // 1 = positive travel
  logic        homed_q;     // Completed since last start
  logic        start_d1_q;  // Previous start bit
  logic        home_d1_q;   // Previous home switch
  logic        lim_seen_q;  // Limit reached this run
  logic [31:0] trav_q;      // Travel past the limit
  logic [16:0] pre_q;       // Millisecond prescaler
  logic [15:0] blk_cnt_q;   // Elapsed push time
  logic [31:0] speed_q;     // Speed output flop
  logic        fault_q;     // Fault output flop
  logic        busy_q;      // Busy output flop

  // Bus handshake flops
  logic        aw_rdy_q;
  logic        ar_rdy_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  // Write channel: address and data are taken together
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~aw_rdy_q
               & ~bvalid_q;
  wire wr_en = aw_rdy_q;
  wire rd_go = s_axi_arvalid & ~ar_rdy_q & ~rvalid_q;
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}},
                       {8{s_axi_wstrb[2]}},
                       {8{s_axi_wstrb[1]}},
                       {8{s_axi_wstrb[0]}}};

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [31:0] m
  );
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  wire [7:0] wa = s_axi_awaddr;
  wire wr_ctrl  = wr_en && wa == ahs_pkg::OFS_CTRL;
  wire wr_mode  = wr_en && wa == ahs_pkg::OFS_MODE;
  wire wr_meth  = wr_en && wa == ahs_pkg::OFS_METHOD;
  wire wr_hofs  = wr_en && wa == ahs_pkg::OFS_HOME_OFS;
  wire wr_spsw  = wr_en && wa == ahs_pkg::OFS_SPD_SW;
  wire wr_spzr  = wr_en && wa == ahs_pkg::OFS_SPD_ZERO;
  wire wr_acc   = wr_en && wa == ahs_pkg::OFS_ACCEL;
  wire wr_tol   = wr_en && wa == ahs_pkg::OFS_TOL_BAND;
  wire wr_bcur  = wr_en && wa == ahs_pkg::OFS_BLK_CUR;
  wire wr_bms   = wr_en && wa == ahs_pkg::OFS_BLK_MS;
  wire wr_pos   = wr_en && wa == ahs_pkg::OFS_POS;
  wire wr_stat  = wr_en && wa == ahs_pkg::OFS_STATUS;
  wire wr_hit   = wr_ctrl | wr_mode | wr_meth | wr_hofs
                | wr_spsw | wr_spzr | wr_acc | wr_tol
                | wr_bcur | wr_bms | wr_pos | wr_stat;

  // Read decode; unmapped reads give zero and an error
  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      ahs_pkg::OFS_CTRL:     rd_val = ctrl_q;
      ahs_pkg::OFS_MODE:     rd_val = {24'h0, mode_q};
      ahs_pkg::OFS_METHOD:   rd_val = {24'h0, method_q};
      ahs_pkg::OFS_STATUS:   rd_val = status_q;
      ahs_pkg::OFS_HOME_OFS: rd_val = home_ofs_q;
      ahs_pkg::OFS_SPD_SW:   rd_val = spd_sw_q;
      ahs_pkg::OFS_SPD_ZERO: rd_val = spd_zero_q;
      ahs_pkg::OFS_ACCEL:    rd_val = accel_q;
      ahs_pkg::OFS_TOL_BAND: rd_val = tol_q;
      ahs_pkg::OFS_BLK_CUR:  rd_val = {16'h0, blk_cur_q};
      ahs_pkg::OFS_BLK_MS:   rd_val = {16'h0, blk_ms_q};
      ahs_pkg::OFS_POS:      rd_val = pos_q;
      default:
      begin
        rd_val = ahs_pkg::RST_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Method decode: magnitude, block flag, profile base
  wire       neg    = method_q[7];
  wire [7:0] m_abs  = neg ? 8'(-method_q) : method_q;
  wire       m_idx  = (m_abs >= 8'd1 && m_abs <= 8'd14)
                    || m_abs == 8'd33 || m_abs == 8'd34;
  wire       m_noix = m_abs >= 8'd17 && m_abs <= 8'd30;
  wire [7:0] base   = m_noix ? 8'(m_abs - 8'd16) : m_abs;
  // Negative numbers must name limit profile 1-2 or home profile 7-14
  wire       blk_ok = base <= 8'd2
                    || (base >= 8'd7 && base <= 8'd14);
  wire       m_ok   = neg ? (blk_ok && (m_idx || m_noix))
                          : (m_idx || m_noix
                             || m_abs == 8'd35);
  wire       m_now  = !neg && m_abs == 8'd35;
  wire       m_next = m_abs >= 8'd33;
  wire       m_lim  = base <= 8'd2;
  // Left edge for 3,4 and the upper home profiles
  wire       m_left = base <= 8'd4 || base >= 8'd11;
  // Even profiles outside 7-14 start positive; 7-10 watch positive, 11-14 negative
  wire       dir0   = base >= 8'd7 && base <= 8'd14
                    ? base <= 8'd10 : ~base[0];

  // Start edge only in homing mode; abort level when start drops or mode leaves homing
  wire in_mode  = mode_q == ahs_pkg::MODE_HOMING;
  wire start_b  = ctrl_q[ahs_pkg::START_BIT];
  wire go       = in_mode && start_b && !start_d1_q;
  wire busy     = st_q == ahs_pkg::ST_SEEK
               || st_q == ahs_pkg::ST_PUSH
               || st_q == ahs_pkg::ST_ZERO;
  wire abort    = busy && (!start_b || !in_mode);

  // Stop events: current threshold replaces limits
  wire blocked  = current_in > blk_cur_q;
  wire lim_dir  = dir_q ? lim_pos_in : lim_neg_in;
  wire stop_hit = neg ? blocked : lim_dir;
  wire sw_rise  = home_sw_in && !home_d1_q;
  wire sw_fall  = !home_sw_in && home_d1_q;
  // Wanted home edge depends on side and direction
  wire edge_hit = (m_left == dir_q) ? sw_rise : sw_fall;
  wire [31:0] dlt  = {{16{pos_delta_in[15]}}, pos_delta_in};
  wire [31:0] dabs = dlt[31] ? 32'(-dlt) : dlt;
  wire lim_any  = lim_pos_in | lim_neg_in;
  wire over_tol = lim_seen_q && trav_q > tol_q;
  wire ms_tick  = pre_q == 17'(MS_CYCLES - 1);
  wire push_end = blk_cnt_q >= blk_ms_q;
  // Block push completes the switch phase
  wire sw_done  = st_q == ahs_pkg::ST_PUSH && push_end;

  // Next sequencer state
  ahs_pkg::ahs_state_t st_d;
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ahs_pkg::ST_IDLE, ahs_pkg::ST_DONE,
      ahs_pkg::ST_ERR:
      begin
        if (go && !m_ok)
          st_d = ahs_pkg::ST_ERR;
        else if (go && neg && !closed_loop_in)
          st_d = ahs_pkg::ST_ERR;
        else if (go && m_now)
          st_d = ahs_pkg::ST_DONE;
        else if (go && op_enabled_in)
          st_d = m_next ? ahs_pkg::ST_ZERO
                        : ahs_pkg::ST_SEEK;
        else if (st_q == ahs_pkg::ST_DONE && !start_b)
          st_d = ahs_pkg::ST_IDLE;
      end
      ahs_pkg::ST_SEEK:
      begin
        if (m_lim && stop_hit)
          st_d = neg ? ahs_pkg::ST_PUSH
               : m_idx ? ahs_pkg::ST_ZERO
                       : ahs_pkg::ST_DONE;
        else if (!m_lim && edge_hit)
          st_d = m_idx ? ahs_pkg::ST_ZERO
                       : ahs_pkg::ST_DONE;
      end
      ahs_pkg::ST_PUSH:
      begin
        if (push_end)
          st_d = m_idx ? ahs_pkg::ST_ZERO
                       : ahs_pkg::ST_DONE;
      end
      ahs_pkg::ST_ZERO:
      begin
        if (index_in)
          st_d = ahs_pkg::ST_DONE;
      end
    endcase
    if (abort)
      st_d = ahs_pkg::ST_IDLE;
    if (busy && over_tol)
      st_d = ahs_pkg::ST_ERR;
  end

  // Direction: profile start, reverse at a limit or block
  logic dir_d;
  always_comb
  begin
    dir_d = dir_q;
    if (st_q != st_d && st_d != ahs_pkg::ST_IDLE
        && !busy)
      dir_d = dir0;
    else if (st_q == ahs_pkg::ST_SEEK && !m_lim
             && stop_hit)
      dir_d = ~dir_q;
    else if (st_d == ahs_pkg::ST_ZERO && m_lim
             && st_q != ahs_pkg::ST_ZERO)
      dir_d = ~dir_q;
  end

  // Speed per phase, signed by direction
  // Push keeps driving into the block at switch speed
  wire [31:0] spd_mag = st_d == ahs_pkg::ST_SEEK
                     || st_d == ahs_pkg::ST_PUSH
                        ? spd_sw_q
                      : st_d == ahs_pkg::ST_ZERO
                        ? spd_zero_q : 32'h0;
  wire [31:0] speed_d = dir_d ? spd_mag : 32'(-spd_mag);
  wire entering_done = st_d == ahs_pkg::ST_DONE
                    && st_q != ahs_pkg::ST_DONE;
  // Busy for the next cycle, so the busy pin comes from a flop
  wire busy_d = st_d == ahs_pkg::ST_SEEK
             || st_d == ahs_pkg::ST_PUSH
             || st_d == ahs_pkg::ST_ZERO;

  // Status word: error, homed and target bits
  logic [31:0] status_d;
  always_comb
  begin
    status_d = ahs_pkg::RST_ZERO;
    status_d[ahs_pkg::ST_ERR_BIT] =
      st_q == ahs_pkg::ST_ERR;
    status_d[ahs_pkg::ST_HOMED_BIT] = homed_q;
    status_d[ahs_pkg::ST_TGT_BIT] = busy ? 1'b0
      : (st_q == ahs_pkg::ST_IDLE) ? 1'b1
      : standstill_in;
  end

  // Register writes, software side
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      ctrl_q     <= ahs_pkg::RST_ZERO;
      mode_q     <= 8'h0;
      method_q   <= 8'h0;
      home_ofs_q <= ahs_pkg::RST_ZERO;
      spd_sw_q   <= ahs_pkg::RST_ZERO;
      spd_zero_q <= ahs_pkg::RST_ZERO;
      accel_q    <= ahs_pkg::RST_ZERO;
      tol_q      <= ahs_pkg::RST_ZERO;
      blk_cur_q  <= 16'h0;
      blk_ms_q   <= 16'h0;
    end
    else
    begin
      if (wr_ctrl) ctrl_q <= merge(ctrl_q, s_axi_wdata, wmask);
      if (wr_mode && s_axi_wstrb[0])
        mode_q <= s_axi_wdata[7:0];
      if (wr_meth && s_axi_wstrb[0])
        method_q <= s_axi_wdata[7:0];
      if (wr_hofs)
        home_ofs_q <= merge(home_ofs_q, s_axi_wdata, wmask);
      if (wr_spsw)
        spd_sw_q <= merge(spd_sw_q, s_axi_wdata, wmask);
      if (wr_spzr)
        spd_zero_q <= merge(spd_zero_q, s_axi_wdata, wmask);
      if (wr_acc)
        accel_q <= merge(accel_q, s_axi_wdata, wmask);
      if (wr_tol)
        tol_q <= merge(tol_q, s_axi_wdata, wmask);
      if (wr_bcur)
        blk_cur_q <= 16'(merge({16'h0, blk_cur_q},
                               s_axi_wdata, wmask));
      if (wr_bms)
        blk_ms_q <= 16'(merge({16'h0, blk_ms_q},
                              s_axi_wdata, wmask));
    end
  end

  // Sequencer, position and outputs
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      st_q       <= ahs_pkg::ST_IDLE;
      dir_q      <= 1'b0;
      homed_q    <= 1'b0;
      start_d1_q <= 1'b0;
      home_d1_q  <= 1'b0;
      pos_q      <= ahs_pkg::RST_ZERO;
      speed_q    <= ahs_pkg::RST_ZERO;
      status_q   <= ahs_pkg::RST_STATUS;
      fault_q    <= 1'b0;
      busy_q     <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      busy_q     <= busy_d;
      dir_q      <= dir_d;
      start_d1_q <= start_b;
      home_d1_q  <= home_sw_in;
      speed_q    <= speed_d;
      status_q   <= status_d;
      // Homed clears on start, sets only at completion
      if (entering_done)
        homed_q <= 1'b1;
      else if (go || st_d == ahs_pkg::ST_ERR)
        homed_q <= 1'b0;
      // Completion loads the home offset
      if (entering_done)
        pos_q <= home_ofs_q;
      else if (wr_pos)
        pos_q <= merge(pos_q, s_axi_wdata, wmask);
      else
        pos_q <= pos_q + dlt;
      // Overtravel fault holds until the next start
      if (busy && over_tol)
        fault_q <= 1'b1;
      else if (go)
        fault_q <= 1'b0;
    end
  end

  // Overtravel past a limit, and block push timer
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || go)
    begin
      lim_seen_q <= 1'b0;
      trav_q     <= ahs_pkg::RST_ZERO;
    end
    else if (lim_any || lim_seen_q)
    begin
      lim_seen_q <= 1'b1;
      trav_q     <= trav_q + dabs;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n || st_q != ahs_pkg::ST_PUSH)
    begin
      pre_q     <= 17'h0;
      blk_cnt_q <= 16'h0;
    end
    else
    begin
      pre_q <= ms_tick ? 17'h0 : 17'(pre_q + 17'h1);
      if (ms_tick)
        blk_cnt_q <= blk_cnt_q + 16'h1;
    end
  end

  // AXI4-Lite handshakes; one write and one read at a time
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      aw_rdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= ahs_pkg::RESP_OKAY;
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q  <= ahs_pkg::RESP_OKAY;
      rdata_q  <= ahs_pkg::RST_ZERO;
    end
    else
    begin
      aw_rdy_q <= wr_go;
      if (wr_en)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? ahs_pkg::RESP_OKAY
                           : ahs_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
      ar_rdy_q <= rd_go;
      if (ar_rdy_q)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_val;
        rresp_q  <= rd_hit ? ahs_pkg::RESP_OKAY
                           : ahs_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready  = aw_rdy_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign speed_cmd     = speed_q;
  assign accel_cmd     = accel_q;
  assign fault_out     = fault_q;
  assign homing_busy   = busy_q;

  AST_MODE: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    busy && !in_mode |=> st_q == ahs_pkg::ST_IDLE
                      || st_q == ahs_pkg::ST_ERR)
    else $error("homing ran outside homing mode");
  AST_ABORT: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    busy && !start_b && !over_tol
    |=> st_q == ahs_pkg::ST_IDLE ##1 !status_q[12])
    else $error("clearing start did not abort");
  AST_RUNSTAT: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    busy |=> status_q[12:10] == 3'b000)
    else $error("running status wrong");
  AST_ERRSTAT: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    st_q == ahs_pkg::ST_ERR |=> status_q[13]
      && !status_q[12] && status_q[10] == $past(standstill_in))
    else $error("error status wrong");
  AST_HOMED: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    $rose(homed_q) |-> st_q == ahs_pkg::ST_DONE)
    else $error("homed set without completion");
  AST_OFFSET: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    entering_done && !wr_hofs |=> pos_q == $past(home_ofs_q))
    else $error("position not loaded with offset");
  AST_TOL: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    busy && over_tol |=> fault_out
      && st_q == ahs_pkg::ST_ERR && speed_cmd == 32'h0)
    else $error("overtravel did not fault");
  AST_BLKCL: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    go && neg && !closed_loop_in |=> st_q == ahs_pkg::ST_ERR)
    else $error("block homing without closed loop");
  AST_SPEED: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    st_q == ahs_pkg::ST_SEEK && st_d == ahs_pkg::ST_SEEK
    |=> speed_cmd == $past(dir_d ? spd_sw_q : 32'(-spd_sw_q)))
    else $error("switch search speed wrong");
endmodule : ahs_homing

// file: bench/ahs_motor_model.sv
module ahs_motor_model (
  input  wire logic        core_clk,      // Core clock
  input  wire logic [31:0] speed_cmd,     // Speed from sequencer
  input  wire logic        blk_mode,      // Hard stops, no limits
  output logic             index_in,      // Index pulse
  output logic             home_sw_in,    // Home switch
  output logic             lim_pos_in,    // Positive limit
  output logic             lim_neg_in,    // Negative limit
  output logic [15:0]      current_in,    // Motor current
  output logic [15:0]      pos_delta_in,  // Travel per cycle
  output logic             standstill_in  // At rest
);
  timeunit 1ns;
  timeprecision 1ps;
  int  p = 0;                             // Shaft position
  wire mv = speed_cmd != 32'h0;           // Commanded to move
  wire ng = speed_cmd[31];                // Negative direction
  wire at_stop = blk_mode && (p <= -40 || p >= 40); // On a hard stop
  wire jam = at_stop && (ng ? p <= -40 : p >= 40);  // Pushing into it
  // Switches sit at fixed places; index only shows while turning
  assign lim_neg_in = !blk_mode && p <= -40;
  assign lim_pos_in = !blk_mode && p >= 40;
  assign home_sw_in = p >= 10 && p <= 20;
  assign index_in = mv && p[2:0] == 3'h3;
  // Current rises on a stop even at rest, so a push phase sees it
  assign current_in = at_stop ? 16'h0100 : 16'h0010;
  assign pos_delta_in = (mv && !jam) ? (ng ? 16'hffff : 16'h0001) : 16'h0000;
  // One count a cycle; a hard stop clamps travel
  always_ff @(posedge core_clk)
  begin
    p <= p + $signed(pos_delta_in);
    standstill_in <= !mv;
  end
endmodule : ahs_motor_model

// file: bench/axis_homing_sequencer_bench.sv
module axis_homing_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0, reset_n = 0;        // Clock and reset
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0; // Addresses
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;     // Data
  logic [3:0]  s_axi_wstrb = 4'hf;               // All lanes
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;      // Answers
  logic [1:0]  s_axi_bresp, s_axi_rresp;         // Responses
  logic        index_in, home_sw_in, lim_pos_in, lim_neg_in, standstill_in;
  logic [15:0] current_in, pos_delta_in;         // Motor feedback
  logic        closed_loop_in = 0, op_enabled_in = 1, blk_mode = 0;
  logic [31:0] speed_cmd, accel_cmd;             // Drive commands
  logic        fault_out, homing_busy;           // Sequencer state
  int          mismatches = 0, compares = 0;     // Tallies
  int          c;                                // Push cycle count
  logic [7:0]  c_err [3] = '{8'd15, 8'hef, 8'hfd}; // Refused methods
  initial forever #4 core_clk = ~core_clk;
  // Short millisecond keeps the push phase at eight cycles
  ahs_homing #(.MS_CYCLES(4)) i_dut (.core_clk, .reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .index_in,
    .home_sw_in, .lim_pos_in, .lim_neg_in, .current_in, .pos_delta_in,
    .standstill_in, .closed_loop_in, .op_enabled_in, .speed_cmd,
    .accel_cmd, .fault_out, .homing_busy);
  ahs_motor_model i_motor (.core_clk, .speed_cmd, .blk_mode, .index_in,
    .home_sw_in, .lim_pos_in, .lim_neg_in, .current_in, .pos_delta_in,
    .standstill_in);
  task automatic complete_run;
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Every open-ended wait goes through here so a hang ends the run
  task automatic step(inout int n);
    @(posedge core_clk);
    n++;
    if (n > 2000)
    begin
      mismatches++;
      complete_run;
    end
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    step(n);
    while (s_axi_awready !== 1'b1) step(n);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    s_axi_bready <= 1;
    step(n);
    while (s_axi_bvalid !== 1'b1) step(n);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    step(n);
    while (s_axi_arready !== 1'b1) step(n);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    step(n);
    while (s_axi_rvalid !== 1'b1) step(n);
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 0;
  endtask : rd
  // Start needs the control bit low first, then high
  task automatic go(input logic [7:0] m);
    wr(ahs_pkg::OFS_METHOD, {24'h0, m}, ahs_pkg::RESP_OKAY);
    wr(ahs_pkg::OFS_CTRL, 32'h0, ahs_pkg::RESP_OKAY);
    wr(ahs_pkg::OFS_CTRL, 32'h10, ahs_pkg::RESP_OKAY);
    repeat (4) @(posedge core_clk);
  endtask : go
  task automatic until_idle;
    int n;
    n = 0;
    c = 0;
    while (homing_busy !== 1'b0)
    begin
      // Count only cycles that still drive into a loaded stop
      if (current_in > 16'h0080 && speed_cmd !== 32'h0)
        c++;
      step(n);
    end
  endtask : until_idle
  initial
  begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1;
    rd(ahs_pkg::OFS_STATUS, 32'h0400, 2'h0);
    rd(8'h40, 32'h0, ahs_pkg::RESP_SLVERR);
    wr(8'h40, 32'h1, ahs_pkg::RESP_SLVERR);
    wr(ahs_pkg::OFS_HOME_OFS, 32'h1234, 2'h0);
    wr(ahs_pkg::OFS_SPD_SW, 32'h5, 2'h0);
    wr(ahs_pkg::OFS_SPD_ZERO, 32'h2, 2'h0);
    wr(ahs_pkg::OFS_ACCEL, 32'h9, 2'h0);
    wr(ahs_pkg::OFS_TOL_BAND, 32'h64, 2'h0);
    wr(ahs_pkg::OFS_BLK_CUR, 32'h80, 2'h0);
    wr(ahs_pkg::OFS_BLK_MS, 32'h2, 2'h0);
    chk(accel_cmd, 32'h9);
    wr(ahs_pkg::OFS_MODE, 32'h6, 2'h0);
    go(8'd17);
    chk(speed_cmd, 32'hffff_fffb);
    rd(ahs_pkg::OFS_STATUS, 32'h0, 2'h0);
    until_idle;
    rd(ahs_pkg::OFS_STATUS, 32'h1400, 2'h0);
    rd(ahs_pkg::OFS_POS, 32'h1234, 2'h0);
    go(8'd1);
    c = 0;
    while (speed_cmd !== 32'h2) step(c);
    chk(speed_cmd, 32'h2);
    until_idle;
    rd(ahs_pkg::OFS_STATUS, 32'h1400, 2'h0);
    go(8'd18);
    chk({31'h0, homing_busy}, 32'h1);
    wr(ahs_pkg::OFS_CTRL, 32'h0, 2'h0);
    repeat (4) @(posedge core_clk);
    rd(ahs_pkg::OFS_STATUS, 32'h0400, 2'h0);
    wr(ahs_pkg::OFS_MODE, 32'h1, 2'h0);
    go(8'd35);
    rd(ahs_pkg::OFS_STATUS, 32'h0400, 2'h0);
    wr(ahs_pkg::OFS_MODE, 32'h6, 2'h0);
    op_enabled_in <= 0;
    go(8'd35);
    rd(ahs_pkg::OFS_STATUS, 32'h1400, 2'h0);
    op_enabled_in <= 1;
    // Unknown method, block without closed loop, unlisted block method
    foreach (c_err[i])
    begin
      closed_loop_in <= (i == 2);
      go(c_err[i]);
      rd(ahs_pkg::OFS_STATUS, 32'h2400, 2'h0);
    end
    blk_mode <= 1;
    go(8'hef);
    until_idle;
    chk({31'h0, c >= 8}, 32'h1);
    rd(ahs_pkg::OFS_STATUS, 32'h1400, 2'h0);
    blk_mode <= 0;
    wr(ahs_pkg::OFS_TOL_BAND, 32'h0, 2'h0);
    go(8'd1);
    until_idle;
    chk({31'h0, fault_out}, 32'h1);
    rd(ahs_pkg::OFS_STATUS, 32'h2400, 2'h0);
    // Left home edge from inside the negative limit: reverse, then rise
    wr(ahs_pkg::OFS_TOL_BAND, 32'h64, 2'h0);
    go(8'd19);
    until_idle;
    chk({31'h0, i_motor.p >= 10 && i_motor.p <= 12}, 32'h1);
    rd(ahs_pkg::OFS_STATUS, 32'h1400, 2'h0);
    complete_run;
  end
endmodule : axis_homing_sequencer_bench
